// ---- rtl/cabe_core.sv ----
// Execution unit for arithmetic, logic and program-flow operations of an 8-bit core.
// Assumes a decoder on the same clock that issues decoded operations while busy is low.
//
// Operation
// [RULE1] Register add and add-with-carry write destination in one cycle, five flags.
// [RULE2] Word immediate add on a register pair, two cycles, Z C N V S.
// [RULE3] Register subtract and subtract-with-borrow, one cycle, five flags.
// [RULE4] Constant subtract and constant subtract-with-borrow, one cycle, five flags.
// [RULE5] Word immediate subtract on a register pair, two cycles, Z C N V S.
// [RULE6] AND, OR, XOR with register or constant: one cycle, Z N V only.
// [RULE7] Set bits ORs mask in; clear bits ANDs with 0xFF minus mask.
// [RULE8] Zero-or-minus test ANDs register with itself, keeps value, Z N V.
// [RULE9] Integer multiplies put 16-bit product in R1:R0, two cycles, Z C.
// [RULE10] Fractional multiplies shift product left one bit, two cycles, Z C.
// [RULE11] Relative invoke loads PC plus offset plus one, three cycles, no flags.
// [RULE12] Pointer goto loads PC from the pointer pair, two cycles, no flags.
// [RULE13] Pointer invoke loads PC from the pointer pair, three cycles, no flags.
// [RULE14] Direct invoke loads PC with absolute target, four cycles, no flags.
// [RULE15] Equal skip advances PC by two or three when equal; 1/2/3 cycles.
// [RULE16] Compares set five flags from the difference, destination unchanged, one cycle.
// [RULE17] Flags an operation does not affect keep their previous value.
// [RULE18] Invokes push the return address on the stack before jumping.

`timescale 1ns/100ps
`default_nettype none

module cabe_core (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Operation issue
  input wire logic issue_valid,
  input wire cabe_pkg::cabe_op_t issue_op,
  input wire logic [4:0] issue_rd,
  input wire logic [4:0] issue_rr,
  input wire logic [7:0] issue_imm,
  input wire logic [11:0] issue_offset,
  input wire logic [15:0] issue_target,
  input wire logic issue_next_long,
  // Register observation
  input wire logic [4:0] peek_idx,
  output logic [7:0] peek_data_q,
  // Core state
  output logic busy_q,
  output logic [15:0] pc_q,
  output logic [7:0] sreg_q,
  output logic [3:0] stack_ptr_q
);

  ////////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [2:0] left;
    logic busy;
    logic [31:0][7:0] regs;
    logic [15:0] pc;
    logic [7:0] sreg;
    logic [cabe_pkg::STACK_DEPTH-1:0][15:0] stack;
    logic [3:0] sp;
    logic [7:0] peek;
  } cabe_core_state_t;

  localparam cabe_core_state_t RESET_STATE = '{
    pc: cabe_pkg::PC_RESET,
    sreg: cabe_pkg::SREG_RESET,
    sp: cabe_pkg::SP_RESET,
    default: '0
  };

  // Result of an 8-bit add: {half carry, overflow, carry, sum}.
  function automatic logic [10:0] cabe_add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] s;
    logic h;
    logic v;
    s = {1'h0, a} + {1'h0, b} + {8'h00, cin};
    h = (a[3] & b[3]) | (b[3] & ~s[3]) | (~s[3] & a[3]);
    v = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
    return {h, v, s[8], s[7:0]};
  endfunction

  // Result of an 8-bit subtract: {half borrow, overflow, borrow, difference}.
  function automatic logic [10:0] cabe_sub8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [7:0] r;
    logic h;
    logic v;
    logic c;
    r = a - b - {7'h00, cin};
    h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    return {h, v, c, r};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  cabe_core_state_t cs;
  cabe_core_state_t nx;

  always_comb begin
    logic [7:0] d;
    logic [7:0] r;
    logic [7:0] k;
    logic [4:0] rd_hi;
    logic [10:0] ar;
    logic [7:0] res;
    logic [15:0] w;
    logic [15:0] wres;
    logic signed [8:0] ma;
    logic signed [8:0] mb;
    logic signed [17:0] mp;
    logic [15:0] prod;
    logic [7:0] f;
    logic [2:0] cyc;
    logic wr;
    logic arith;
    logic logic_op;
    logic keep_z;
    logic [15:0] ret_addr;
    logic push;
    d = cs.regs[issue_rd];
    r = cs.regs[issue_rr];
    k = issue_imm;
    rd_hi = issue_rd + 5'h01;
    ar = 11'h000;
    res = 8'h00;
    w = {cs.regs[rd_hi], d};
    wres = 16'h0000;
    ma = 9'h000;
    mb = 9'h000;
    mp = 18'h00000;
    prod = 16'h0000;
    f = cs.sreg;
    cyc = cabe_pkg::CYC_SINGLE;
    wr = 1'h0;
    arith = 1'h0;
    logic_op = 1'h0;
    keep_z = 1'h0;
    ret_addr = cs.pc + cabe_pkg::PC_STEP_SHORT;
    push = 1'h0;

    nx = cs;
    nx.peek = cs.regs[peek_idx];
    nx.left = (cs.left != 3'h0) ? cs.left - 3'h1 : 3'h0;

    if (cs.left == 3'h0 && issue_valid) begin
      nx.pc = cs.pc + cabe_pkg::PC_STEP_SHORT;
      unique case (issue_op)
        cabe_pkg::op_add: begin
          ar = cabe_add8(d, r, 1'h0); // RULE1
          wr = 1'h1;
          arith = 1'h1;
        end
        cabe_pkg::op_add_carry: begin
          ar = cabe_add8(d, r, cs.sreg[cabe_pkg::FLAG_C]); // RULE1
          wr = 1'h1;
          arith = 1'h1;
        end
        cabe_pkg::op_sub: begin
          ar = cabe_sub8(d, r, 1'h0); // RULE3
          wr = 1'h1;
          arith = 1'h1;
        end
        cabe_pkg::op_borrow_difference_regs: begin
          ar = cabe_sub8(d, r, cs.sreg[cabe_pkg::FLAG_C]); // RULE3
          wr = 1'h1;
          arith = 1'h1;
          keep_z = 1'h1;
        end
        cabe_pkg::op_constant_difference: begin
          ar = cabe_sub8(d, k, 1'h0); // RULE4
          wr = 1'h1;
          arith = 1'h1;
        end
        cabe_pkg::op_borrow_const_difference: begin
          ar = cabe_sub8(d, k, cs.sreg[cabe_pkg::FLAG_C]); // RULE4
          wr = 1'h1;
          arith = 1'h1;
          keep_z = 1'h1;
        end
        cabe_pkg::op_compare: begin
          ar = cabe_sub8(d, r, 1'h0); // RULE16
          arith = 1'h1;
        end
        cabe_pkg::op_compare_carry: begin
          ar = cabe_sub8(d, r, cs.sreg[cabe_pkg::FLAG_C]); // RULE16
          arith = 1'h1;
          keep_z = 1'h1;
        end
        cabe_pkg::op_immediate_compare: begin
          ar = cabe_sub8(d, k, 1'h0); // RULE16
          arith = 1'h1;
        end
        cabe_pkg::op_negate: begin
          ar = cabe_sub8(8'h00, d, 1'h0);
          ar[8] = (ar[7:0] != 8'h00);
          wr = 1'h1;
          arith = 1'h1;
        end
        cabe_pkg::op_word_immediate_sum, cabe_pkg::op_word_immediate_difference: begin
          cyc = cabe_pkg::CYC_WORD; // RULE2 RULE5
          if (issue_op == cabe_pkg::op_word_immediate_sum) begin
            wres = w + {10'h000, k[5:0]}; // RULE2
            f[cabe_pkg::FLAG_V] = ~w[15] & wres[15];
            f[cabe_pkg::FLAG_C] = ~wres[15] & w[15];
          end else begin
            wres = w - {10'h000, k[5:0]}; // RULE5
            f[cabe_pkg::FLAG_V] = w[15] & ~wres[15];
            f[cabe_pkg::FLAG_C] = wres[15] & ~w[15];
          end
          f[cabe_pkg::FLAG_N] = wres[15];
          f[cabe_pkg::FLAG_Z] = (wres == 16'h0000);
          f[cabe_pkg::FLAG_S] = wres[15] ^ f[cabe_pkg::FLAG_V];
          nx.regs[issue_rd] = wres[7:0];
          nx.regs[rd_hi] = wres[15:8];
        end
        cabe_pkg::op_and: begin
          res = d & r; // RULE6
          logic_op = 1'h1;
        end
        cabe_pkg::op_mask_with_const: begin
          res = d & k; // RULE6
          logic_op = 1'h1;
        end
        cabe_pkg::op_or: begin
          res = d | r; // RULE6
          logic_op = 1'h1;
        end
        cabe_pkg::op_or_const: begin
          res = d | k; // RULE6
          logic_op = 1'h1;
        end
        cabe_pkg::op_xor: begin
          res = d ^ r; // RULE6
          logic_op = 1'h1;
        end
        cabe_pkg::op_bit_set_mask: begin
          res = d | k; // RULE7
          logic_op = 1'h1;
        end
        cabe_pkg::op_bit_clear_mask: begin
          res = d & (8'hFF - k); // RULE7
          logic_op = 1'h1;
        end
        cabe_pkg::op_zero_minus_test: begin
          res = d & d; // RULE8
          logic_op = 1'h1;
        end
        cabe_pkg::op_clear: begin
          res = d ^ d;
          logic_op = 1'h1;
        end
        cabe_pkg::op_increment, cabe_pkg::op_decrement: begin
          res = (issue_op == cabe_pkg::op_increment) ? d + 8'h01 : d - 8'h01;
          logic_op = 1'h1;
        end
        cabe_pkg::op_complement: begin
          res = 8'hFF - d;
          logic_op = 1'h1;
          f[cabe_pkg::FLAG_C] = 1'h1;
        end
        cabe_pkg::op_set_all: begin
          nx.regs[issue_rd] = 8'hFF;
        end
        cabe_pkg::op_product_unsigned, cabe_pkg::op_product_signed, cabe_pkg::op_product_signed_by_unsigned,
        cabe_pkg::op_fraction_product_unsigned, cabe_pkg::op_fraction_product_signed,
        cabe_pkg::op_fraction_product_signed_by_unsigned: begin
          cyc = cabe_pkg::CYC_PRODUCT; // RULE9 RULE10
          ma = $signed({(issue_op inside {cabe_pkg::op_product_signed, cabe_pkg::op_product_signed_by_unsigned,
                                          cabe_pkg::op_fraction_product_signed,
                                          cabe_pkg::op_fraction_product_signed_by_unsigned}) & d[7], d});
          mb = $signed({(issue_op inside {cabe_pkg::op_product_signed,
                                          cabe_pkg::op_fraction_product_signed}) & r[7], r});
          mp = ma * mb;
          prod = mp[15:0];
          f[cabe_pkg::FLAG_C] = prod[15]; // RULE9
          if (issue_op inside {cabe_pkg::op_fraction_product_unsigned, cabe_pkg::op_fraction_product_signed,
                               cabe_pkg::op_fraction_product_signed_by_unsigned}) begin
            prod = {prod[14:0], 1'h0}; // RULE10
          end
          f[cabe_pkg::FLAG_Z] = (prod == 16'h0000);
          nx.regs[cabe_pkg::PROD_LO_IDX] = prod[7:0]; // RULE9
          nx.regs[cabe_pkg::PROD_HI_IDX] = prod[15:8];
        end
        cabe_pkg::op_relative_goto: begin
          cyc = cabe_pkg::CYC_REL_GOTO;
          nx.pc = cs.pc + {{4{issue_offset[11]}}, issue_offset} + cabe_pkg::PC_STEP_SHORT;
        end
        cabe_pkg::op_pointer_goto: begin
          cyc = cabe_pkg::CYC_PTR_GOTO; // RULE12
          nx.pc = {cs.regs[cabe_pkg::PTR_HI_IDX], cs.regs[cabe_pkg::PTR_LO_IDX]}; // RULE12
        end
        cabe_pkg::op_direct_goto: begin
          cyc = cabe_pkg::CYC_DIR_GOTO;
          nx.pc = issue_target;
        end
        cabe_pkg::op_relative_invoke: begin
          cyc = cabe_pkg::CYC_REL_INVOKE; // RULE11
          push = 1'h1;
          nx.pc = cs.pc + {{4{issue_offset[11]}}, issue_offset} + cabe_pkg::PC_STEP_SHORT; // RULE11
        end
        cabe_pkg::op_pointer_invoke: begin
          cyc = cabe_pkg::CYC_PTR_INVOKE; // RULE13
          push = 1'h1;
          nx.pc = {cs.regs[cabe_pkg::PTR_HI_IDX], cs.regs[cabe_pkg::PTR_LO_IDX]}; // RULE13
        end
        cabe_pkg::op_direct_invoke: begin
          cyc = cabe_pkg::CYC_DIR_INVOKE; // RULE14
          push = 1'h1;
          ret_addr = cs.pc + cabe_pkg::PC_STEP_LONG;
          nx.pc = issue_target; // RULE14
        end
        cabe_pkg::op_return, cabe_pkg::op_interrupt_return: begin
          cyc = cabe_pkg::CYC_RETURN;
          nx.sp = cs.sp - 4'h1;
          nx.pc = cs.stack[nx.sp];
          if (issue_op == cabe_pkg::op_interrupt_return) begin
            f[cabe_pkg::FLAG_I] = 1'h1;
          end
        end
        cabe_pkg::op_equal_skip: begin
          if (d == r) begin
            cyc = issue_next_long ? cabe_pkg::CYC_SKIP_LONG : cabe_pkg::CYC_SKIP_SHORT; // RULE15
            nx.pc = cs.pc + (issue_next_long ? cabe_pkg::PC_SKIP_LONG : cabe_pkg::PC_SKIP_SHORT); // RULE15
          end else begin
            cyc = cabe_pkg::CYC_SKIP_NONE;
          end
        end
        cabe_pkg::op_nop: begin
          cyc = cabe_pkg::CYC_SINGLE;
        end
        default: begin
          cyc = cabe_pkg::CYC_SINGLE;
        end
      endcase

      // Adds, subtracts and compares share the five-flag update.
      if (arith) begin
        res = ar[7:0];
        f[cabe_pkg::FLAG_H] = ar[10]; // RULE1 RULE3 RULE4 RULE16
        f[cabe_pkg::FLAG_V] = ar[9];
        f[cabe_pkg::FLAG_C] = ar[8];
        f[cabe_pkg::FLAG_N] = ar[7];
        f[cabe_pkg::FLAG_Z] = (ar[7:0] == 8'h00) & (~keep_z | cs.sreg[cabe_pkg::FLAG_Z]);
        if (wr) begin
          nx.regs[issue_rd] = res;
        end
      end

      // Bitwise group touches Z, N and V; complement also sets C; other flags stay put.
      if (logic_op) begin
        f[cabe_pkg::FLAG_Z] = (res == 8'h00); // RULE6 RULE7 RULE8
        f[cabe_pkg::FLAG_N] = res[7];
        f[cabe_pkg::FLAG_V] = 1'h0;
        if (issue_op == cabe_pkg::op_increment) begin
          f[cabe_pkg::FLAG_V] = (res == 8'h80);
        end
        if (issue_op == cabe_pkg::op_decrement) begin
          f[cabe_pkg::FLAG_V] = (res == 8'h7F);
        end
        nx.regs[issue_rd] = res;
      end

      // Return address goes on the stack in the same edge as the jump.
      if (push) begin
        nx.stack[cs.sp] = ret_addr; // RULE18
        nx.sp = cs.sp + 4'h1;
      end

      nx.sreg = f; // RULE17
      nx.left = cyc - 3'h1;
    end
    nx.busy = (nx.left != 3'h0);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs <= RESET_STATE;
    end else begin
      cs <= nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  assign busy_q = cs.busy;
  assign pc_q = cs.pc;
  assign sreg_q = cs.sreg;
  assign stack_ptr_q = cs.sp;
  assign peek_data_q = cs.peek;

endmodule // cabe_core

`default_nettype wire

// ---- rtl/cabe_pkg.sv ----
// Shared constants and types of the arithmetic and program-flow execution unit.
// Assumes a single 20 MHz core clock and an external decoder that issues one operation at a time.

package cabe_pkg;

  // Operation codes issued by the decoder.
  typedef enum logic [5:0] {
    op_add, op_add_carry, op_word_immediate_sum,
    op_sub, op_constant_difference, op_borrow_difference_regs, op_borrow_const_difference,
    op_word_immediate_difference,
    op_and, op_mask_with_const, op_or, op_or_const, op_xor,
    op_complement, op_negate, op_bit_set_mask, op_bit_clear_mask,
    op_increment, op_decrement, op_zero_minus_test, op_clear, op_set_all,
    op_product_unsigned, op_product_signed, op_product_signed_by_unsigned,
    op_fraction_product_unsigned, op_fraction_product_signed, op_fraction_product_signed_by_unsigned,
    op_relative_goto, op_pointer_goto, op_direct_goto,
    op_relative_invoke, op_pointer_invoke, op_direct_invoke,
    op_return, op_interrupt_return,
    op_equal_skip, op_compare, op_compare_carry, op_immediate_compare,
    op_nop
  } cabe_op_t;

  // Status flag positions.
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;

  // Fixed register indices.
  localparam logic [4:0] PROD_LO_IDX = 5'h00;
  localparam logic [4:0] PROD_HI_IDX = 5'h01;
  localparam logic [4:0] PTR_LO_IDX = 5'h1E;
  localparam logic [4:0] PTR_HI_IDX = 5'h1F;

  // Values after reset, and the depth of the return stack.
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SREG_RESET = 8'h00;
  localparam logic [3:0] SP_RESET = 4'h0;
  localparam int unsigned STACK_DEPTH = 16;

  // Cycle counts per operation class.
  localparam logic [2:0] CYC_SINGLE = 3'h1;
  localparam logic [2:0] CYC_WORD = 3'h2;
  localparam logic [2:0] CYC_PRODUCT = 3'h2;
  localparam logic [2:0] CYC_REL_GOTO = 3'h2;
  localparam logic [2:0] CYC_PTR_GOTO = 3'h2;
  localparam logic [2:0] CYC_DIR_GOTO = 3'h3;
  localparam logic [2:0] CYC_REL_INVOKE = 3'h3;
  localparam logic [2:0] CYC_PTR_INVOKE = 3'h3;
  localparam logic [2:0] CYC_DIR_INVOKE = 3'h4;
  localparam logic [2:0] CYC_RETURN = 3'h4;
  localparam logic [2:0] CYC_SKIP_NONE = 3'h1;
  localparam logic [2:0] CYC_SKIP_SHORT = 3'h2;
  localparam logic [2:0] CYC_SKIP_LONG = 3'h3;

  // Program counter steps.
  localparam logic [15:0] PC_STEP_SHORT = 16'h0001;
  localparam logic [15:0] PC_STEP_LONG = 16'h0002;
  localparam logic [15:0] PC_SKIP_SHORT = 16'h0002;
  localparam logic [15:0] PC_SKIP_LONG = 16'h0003;

endpackage : cabe_pkg

// ---- tb/cabe_core_props.sv ----
// Port-level checker for the execution unit, attached by bind.
// Assumes one clock core_clk and the asynchronous active-low reset_n.
`timescale 1ns/100ps
`default_nettype none
module cabe_core_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Issue
  input wire logic issue_valid,
  input wire cabe_pkg::cabe_op_t issue_op,
  input wire logic [11:0] issue_offset,
  input wire logic [15:0] issue_target,
  // State
  input wire logic busy_q,
  input wire logic [15:0] pc_q,
  input wire logic [7:0] sreg_q,
  input wire logic [3:0] stack_ptr_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic go;
  assign go = issue_valid && !busy_q;
  sequence hold1; busy_q ##1 !busy_q; endsequence
  sequence hold2; busy_q [*2] ##1 !busy_q; endsequence
  sequence hold3; busy_q [*3] ##1 !busy_q; endsequence
  chk_direct_invoke_span: assert property (go && issue_op == cabe_pkg::op_direct_invoke |=>
    pc_q == $past(issue_target) && stack_ptr_q == $past(stack_ptr_q) + 4'h1 ##0 hold3) else $error("direct invoke");
  chk_rel_invoke_span: assert property (go && issue_op == cabe_pkg::op_relative_invoke |=>
    pc_q == $past(pc_q) + {{4{$past(issue_offset[11])}}, $past(issue_offset)} + 16'h0001
    && stack_ptr_q == $past(stack_ptr_q) + 4'h1 && sreg_q == $past(sreg_q) ##0 hold2) else $error("relative invoke");
  chk_ptr_invoke_span: assert property (go && issue_op == cabe_pkg::op_pointer_invoke |=>
    stack_ptr_q == $past(stack_ptr_q) + 4'h1 && $stable(sreg_q) ##0 hold2) else $error("pointer invoke");
  chk_ptr_goto_span: assert property (go && issue_op == cabe_pkg::op_pointer_goto |=>
    $stable(sreg_q) && $stable(stack_ptr_q) ##0 hold1) else $error("pointer goto");
  chk_word_op_flags: assert property (go && issue_op inside {cabe_pkg::op_word_immediate_sum,
    cabe_pkg::op_word_immediate_difference} |=> sreg_q[7:5] == $past(sreg_q[7:5]) ##0 hold1) else $error("word op");
  chk_product_flags: assert property (go && issue_op inside {[cabe_pkg::op_product_unsigned:
    cabe_pkg::op_fraction_product_signed_by_unsigned]} |=> sreg_q[7:2] == $past(sreg_q[7:2]) ##0 hold1)
    else $error("product op");
  chk_logic_flags: assert property (go && issue_op inside {[cabe_pkg::op_and:cabe_pkg::op_xor],
    cabe_pkg::op_bit_set_mask, cabe_pkg::op_bit_clear_mask, cabe_pkg::op_zero_minus_test} |=> !sreg_q[3]
    && sreg_q[7:4] == $past(sreg_q[7:4]) && sreg_q[0] == $past(sreg_q[0]) && pc_q == $past(pc_q) + 16'h0001
    && !busy_q) else $error("logic op");
  chk_arith_single: assert property (go && issue_op inside {cabe_pkg::op_add, cabe_pkg::op_add_carry,
    [cabe_pkg::op_sub:cabe_pkg::op_borrow_const_difference], [cabe_pkg::op_compare:cabe_pkg::op_immediate_compare]}
    |=> pc_q == $past(pc_q) + 16'h0001 && !busy_q && sreg_q[7:6] == $past(sreg_q[7:6])) else $error("arith op");
  chk_skip_span: assert property (go && issue_op == cabe_pkg::op_equal_skip |=> $stable(sreg_q) ##0
    ((pc_q - $past(pc_q) == 16'h0001 && !busy_q) or (pc_q - $past(pc_q) == 16'h0002 ##0 hold1)
    or (pc_q - $past(pc_q) == 16'h0003 ##0 hold2))) else $error("equal skip");
endmodule // cabe_core_props
bind cabe_core cabe_core_props cabe_core_props_inst (.core_clk, .reset_n, .issue_valid, .issue_op, .issue_offset,
  .issue_target, .busy_q, .pc_q, .sreg_q, .stack_ptr_q);
`default_nettype wire

// ---- tb/cabe_core_tb.sv ----
// Self-checking random bench of the execution unit with a behavioural mirror.
// Assumes the unit alone on a 50 ns core_clk, inputs driven at the falling edge.
`timescale 1ns/100ps
`default_nettype none
module cabe_core_tb;
  logic core_clk, reset_n, issue_valid, issue_next_long, busy_q;
  cabe_pkg::cabe_op_t issue_op, op;
  logic [4:0] issue_rd, issue_rr, peek_idx, d, s;
  logic [7:0] issue_imm, peek_data_q, sreg_q, m_f;
  logic [11:0] issue_offset;
  logic [15:0] issue_target, pc_q, m_pc;
  logic [3:0] stack_ptr_q, m_sp;
  logic [7:0] m_r [32];
  logic [15:0] m_stk [16];
  int bad_count, compares, m_cyc, i;
  cabe_core cabe_core_inst (.core_clk, .reset_n, .issue_valid, .issue_op, .issue_rd, .issue_rr, .issue_imm,
    .issue_offset, .issue_target, .issue_next_long, .peek_idx, .peek_data_q, .busy_q, .pc_q, .sreg_q, .stack_ptr_q);
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic push(input logic [15:0] a);
    m_stk[m_sp] = a;
    m_sp = m_sp + 4'h1;
  endtask
  // Mirror of one operation on the bench copy of registers, flags, PC and stack.
  task automatic model(input cabe_pkg::cabe_op_t op, input logic [4:0] d, s, input logic [7:0] k,
    input logic [11:0] o, input logic [15:0] t, input logic nl);
    logic [7:0] a, b, r;
    logic [8:0] x;
    logic [16:0] w;
    logic [15:0] p, pc0;
    logic c, bf;
    a = m_r[d];
    b = m_r[s];
    pc0 = m_pc;
    m_pc = pc0 + 16'h0001;
    m_cyc = 1;
    case (op) inside
      cabe_pkg::op_add, cabe_pkg::op_add_carry: begin
        x = a + b + ((op == cabe_pkg::op_add_carry) & m_f[0]);
        r = x[7:0];
        m_r[d] = r;
        m_f[5:0] = {a[3] & b[3] | b[3] & ~r[3] | ~r[3] & a[3], m_f[4], a[7] & b[7] & ~r[7] | ~a[7] & ~b[7] & r[7],
          r[7], r == 8'h00, x[8]};
      end
      [cabe_pkg::op_sub:cabe_pkg::op_borrow_const_difference], [cabe_pkg::op_compare:cabe_pkg::op_immediate_compare]: begin
        if (op inside {cabe_pkg::op_constant_difference, cabe_pkg::op_borrow_const_difference,
          cabe_pkg::op_immediate_compare}) b = k;
        bf = op inside {cabe_pkg::op_borrow_difference_regs, cabe_pkg::op_borrow_const_difference,
          cabe_pkg::op_compare_carry};
        c = bf & m_f[0];
        x = a - b - c;
        r = x[7:0];
        if (!(op inside {[cabe_pkg::op_compare:cabe_pkg::op_immediate_compare]})) m_r[d] = r;
        m_f[5:0] = {~a[3] & b[3] | b[3] & r[3] | r[3] & ~a[3], m_f[4], a[7] & ~b[7] & ~r[7] | ~a[7] & b[7] & r[7],
          r[7], (r == 8'h00) & (~bf | m_f[1]), x[8]};
      end
      cabe_pkg::op_word_immediate_sum, cabe_pkg::op_word_immediate_difference: begin
        c = op == cabe_pkg::op_word_immediate_sum;
        p = {m_r[d + 5'h01], a};
        w = c ? p + k[5:0] : p - k[5:0];
        {m_r[d + 5'h01], m_r[d]} = w[15:0];
        m_f[3:0] = {(c ? ~p[15] & w[15] : p[15] & ~w[15]), w[15], w[15:0] == 16'h0000, w[16]};
        m_f[4] = m_f[2] ^ m_f[3];
        m_cyc = 2;
      end
      [cabe_pkg::op_and:cabe_pkg::op_xor], cabe_pkg::op_bit_set_mask, cabe_pkg::op_bit_clear_mask,
      cabe_pkg::op_zero_minus_test: begin
        case (op)
          cabe_pkg::op_and: r = a & b;
          cabe_pkg::op_mask_with_const: r = a & k;
          cabe_pkg::op_or: r = a | b;
          cabe_pkg::op_xor: r = a ^ b;
          cabe_pkg::op_bit_clear_mask: r = a & (8'hFF - k);
          cabe_pkg::op_zero_minus_test: r = a & a;
          default: r = a | k;
        endcase
        m_r[d] = r;
        m_f[3:1] = {1'b0, r[7], r == 8'h00};
      end
      [cabe_pkg::op_product_unsigned:cabe_pkg::op_fraction_product_signed_by_unsigned]: begin
        c = op inside {cabe_pkg::op_product_signed, cabe_pkg::op_fraction_product_signed};
        p = $signed({(c | op inside {cabe_pkg::op_product_signed_by_unsigned,
          cabe_pkg::op_fraction_product_signed_by_unsigned}) & a[7], a}) * $signed({c & b[7], b});
        m_f[0] = p[15];
        if (op >= cabe_pkg::op_fraction_product_unsigned) p = p << 1;
        {m_r[1], m_r[0]} = p;
        m_f[1] = p == 16'h0000;
        m_cyc = 2;
      end
      cabe_pkg::op_relative_goto, cabe_pkg::op_relative_invoke: begin
        if (op == cabe_pkg::op_relative_invoke) push(pc0 + 16'h0001);
        m_pc = pc0 + {{4{o[11]}}, o} + 16'h0001;
        m_cyc = (op == cabe_pkg::op_relative_invoke) ? 3 : 2;
      end
      cabe_pkg::op_pointer_goto, cabe_pkg::op_pointer_invoke: begin
        if (op == cabe_pkg::op_pointer_invoke) push(pc0 + 16'h0001);
        m_pc = {m_r[31], m_r[30]};
        m_cyc = (op == cabe_pkg::op_pointer_invoke) ? 3 : 2;
      end
      cabe_pkg::op_direct_goto, cabe_pkg::op_direct_invoke: begin
        if (op == cabe_pkg::op_direct_invoke) push(pc0 + 16'h0002);
        m_pc = t;
        m_cyc = (op == cabe_pkg::op_direct_invoke) ? 4 : 3;
      end
      cabe_pkg::op_return: begin
        m_sp = m_sp - 4'h1;
        m_pc = m_stk[m_sp];
        m_cyc = 4;
      end
      cabe_pkg::op_equal_skip: begin
        if (a == b) m_cyc = nl ? 3 : 2;
        m_pc = pc0 + 16'(m_cyc);
      end
      default: ;
    endcase
  endtask
  task automatic peek(input logic [4:0] i);
    peek_idx = i;
    repeat (2) @(negedge core_clk);
    cmp("reg", m_r[i], peek_data_q);
  endtask
  // Offers one operation, then offers an add while busy which the unit must refuse.
  task automatic run(input cabe_pkg::cabe_op_t op, input logic [4:0] d, s, input logic [7:0] k);
    logic [11:0] o;
    logic [15:0] t;
    logic nl;
    int n;
    o = 12'($urandom);
    t = 16'($urandom);
    nl = 1'($urandom);
    model(op, d, s, k, o, t, nl);
    {issue_valid, issue_op, issue_rd, issue_rr, issue_imm, issue_offset, issue_target, issue_next_long} =
      {1'b1, op, d, s, k, o, t, nl};
    @(negedge core_clk);
    issue_op = cabe_pkg::op_add;
    n = 1;
    while (busy_q === 1'b1 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    issue_valid = 0;
    cmp("cycles", 16'(m_cyc), 16'(n));
    cmp("pc", m_pc, pc_q);
    cmp("sreg", m_f, sreg_q);
    cmp("sp", m_sp, stack_ptr_q);
    peek(d);
    peek(d + 5'h01);
    peek(5'h00);
    peek(5'h01);
  endtask
  task automatic reset_all;
    reset_n = 0;
    repeat (16) @(negedge core_clk);
    cmp("pc", 16'h0000, pc_q);
    cmp("state", 16'h0000, {sreg_q, stack_ptr_q, 3'h0, busy_q});
    reset_n = 1;
    m_r = '{default: 8'h00};
    {m_pc, m_f, m_sp} = '0;
    for (int j = 0; j < 32; j++) run(cabe_pkg::op_or_const, 5'(j), 5'h00, 8'($urandom));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {issue_valid, issue_rd, issue_rr, issue_imm, issue_offset, issue_target, issue_next_long, peek_idx} = '0;
    issue_op = cabe_pkg::op_nop;
    reset_n = 0;
    {bad_count, compares} = '0;
    void'($urandom(71171));
    @(negedge core_clk);
    reset_all();
    run(cabe_pkg::op_mask_with_const, 5'h02, 5'h00, 8'h00);
    run(cabe_pkg::op_bit_set_mask, 5'h02, 5'h00, 8'h80);
    run(cabe_pkg::op_add, 5'h02, 5'h02, 8'h00);
    run(cabe_pkg::op_borrow_difference_regs, 5'h02, 5'h02, 8'h00);
    run(cabe_pkg::op_bit_clear_mask, 5'h02, 5'h00, 8'h0F);
    for (i = 0; i < 400; i++) begin
      if (i == 200) reset_all();
      op = cabe_pkg::cabe_op_t'($urandom_range(40));
      if (op inside {[cabe_pkg::op_complement:cabe_pkg::op_negate], [cabe_pkg::op_increment:cabe_pkg::op_decrement],
        [cabe_pkg::op_clear:cabe_pkg::op_set_all], cabe_pkg::op_return, cabe_pkg::op_interrupt_return}) continue;
      d = 5'($urandom);
      s = $urandom_range(1) ? d : 5'($urandom);
      if (op inside {cabe_pkg::op_word_immediate_sum, cabe_pkg::op_word_immediate_difference}) d = {2'h3, 2'($urandom), 1'b0};
      run(op, d, s, 8'($urandom));
      if (op inside {cabe_pkg::op_relative_invoke, cabe_pkg::op_pointer_invoke, cabe_pkg::op_direct_invoke})
        run(cabe_pkg::op_return, d, s, 8'h00);
    end
    final_report();
  end
  initial begin
    #2000000;
    bad_count++;
    final_report();
  end
endmodule // cabe_core_tb
`default_nettype wire
